// ==== logic/alu_regs.vh ====
/*
  constants for the complement and decimal adjust datapath slice.
  assumes inclusion by bare name from the design files.
*/
`ifndef ALU_REGS_VH
`define ALU_REGS_VH
`define DATA_W 8
`define NIB_LIMIT 4'h9
`define NIB_FIX 4'h6
`define CORR_NONE 8'h00
`define CORR_LOW 8'h06
`define CORR_HIGH 8'h60
`define CORR_BOTH 8'h66
`define ACC_RST 8'h00
`define FLAG_RST 1'h0
`endif

// ==== logic/bcd_corrector.v ====
/*
  combinational decimal adjust of one byte.
  assumes flags and byte are stable for the cycle they are used.
*/
`default_nettype none
`include "alu_regs.vh"
module bcd_corrector (
  input wire [7:0] src,
  input wire half_carry_in,
  input wire carry_in,
  output wire [7:0] result,
  output wire carry_out,
  output wire [7:0] correction
);
  wire low_fix;
  wire high_fix;
  wire [8:0] sum;
  assign low_fix = (src[3:0] > `NIB_LIMIT) | half_carry_in;
  assign high_fix = (src[7:4] > `NIB_LIMIT) | carry_in;
  assign correction = high_fix ? (low_fix ? `CORR_BOTH : `CORR_HIGH) :
                      (low_fix ? `CORR_LOW : `CORR_NONE);
  assign sum = {1'b0, src} + {1'b0, correction};
  assign result = sum[7:0];
  // carry sets on overflow, else holds
  assign carry_out = sum[8] | carry_in;
endmodule
`default_nettype wire

// ==== logic/complement_and_decimal_adjust_alu.v ====
/*
  datapath slice running the complement-to-accumulator and
  decimal-adjust-to-memory instructions.
  assumes the decoder pulses one op strobe per instruction cycle and
  presents the addressed memory byte on mem_rdata that same cycle.
*/
`default_nettype none
`include "alu_regs.vh"
////////////////////////////////////////////////////////////////////
// Overview of operation
// - complement memory byte into accumulator, update zero
// - memory byte untouched by complement
// - decimal adjust writes accumulator result to memory
// - low nibble plus six if above nine/half-carry
// - high nibble plus six if above nine/carry
// - correction is 00, 06, 60 or 66
module complement_and_decimal_adjust_alu #(
  parameter W = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire complement_to_accumulator,
  input wire decimal_adjust_to_memory,
  input wire [W-1:0] mem_rdata,
  input wire acc_load,
  input wire [W-1:0] acc_wdata,
  input wire flag_load,
  input wire zero_wdata,
  input wire carry_wdata,
  input wire half_carry_wdata,
  output reg [W-1:0] acc_q,
  output reg zero_flag_q,
  output reg carry_flag_q,
  output reg half_carry_flag_q,
  output reg mem_we_q,
  output reg [W-1:0] mem_wdata_q
);
  localparam [2:0] OP_NONE = 3'h1;
  localparam [2:0] OP_INVERT = 3'h2;
  localparam [2:0] OP_ADJUST = 3'h4;

  wire [7:0] adj_result;
  wire adj_carry;
  wire [W-1:0] inv_byte;
  wire [2:0] op_sel;
  reg [W-1:0] acc_d;
  reg zero_flag_d;
  reg carry_flag_d;
  reg half_carry_flag_d;
  reg mem_we_d;
  reg [W-1:0] mem_wdata_d;

  ////////////////////////////////////////////////////////////////////
  // complement wins if decoder ever asserts both strobes
  function [2:0] op_decode;
    input inv_strobe;
    input adj_strobe;
    begin
      if (inv_strobe) begin
        op_decode = OP_INVERT;
      end else if (adj_strobe) begin
        op_decode = OP_ADJUST;
      end else begin
        op_decode = OP_NONE;
      end
    end
  endfunction

  function is_zero;
    input [W-1:0] value;
    begin
      is_zero = (value == {W{1'h0}});
    end
  endfunction

  assign op_sel = op_decode(complement_to_accumulator, decimal_adjust_to_memory);

  ////////////////////////////////////////////////////////////////////
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < W; bit_idx = bit_idx + 1) begin : g_invert
      assign inv_byte[bit_idx] = ~mem_rdata[bit_idx];
    end
  endgenerate

  bcd_corrector u_bcd (
    .src(acc_q),
    .half_carry_in(half_carry_flag_q),
    .carry_in(carry_flag_q),
    .result(adj_result),
    .carry_out(adj_carry),
    .correction()
  );

  ////////////////////////////////////////////////////////////////////
  always @* begin
    acc_d = acc_q;
    case (op_sel)
      OP_INVERT: begin
        acc_d = inv_byte;
      end
      OP_ADJUST: begin
        acc_d = acc_q;
      end
      OP_NONE: begin
        if (acc_load) begin
          acc_d = acc_wdata;
        end
      end
      default: begin
        acc_d = acc_q;
      end
    endcase
  end

  always @* begin
    zero_flag_d = zero_flag_q;
    case (op_sel)
      OP_INVERT: begin
        zero_flag_d = is_zero(inv_byte);
      end
      OP_ADJUST: begin
        zero_flag_d = zero_flag_q;
      end
      OP_NONE: begin
        if (flag_load) begin
          zero_flag_d = zero_wdata;
        end
      end
      default: begin
        zero_flag_d = zero_flag_q;
      end
    endcase
  end

  always @* begin
    carry_flag_d = carry_flag_q;
    case (op_sel)
      OP_INVERT: begin
        carry_flag_d = carry_flag_q;
      end
      OP_ADJUST: begin
        carry_flag_d = adj_carry;
      end
      OP_NONE: begin
        if (flag_load) begin
          carry_flag_d = carry_wdata;
        end
      end
      default: begin
        carry_flag_d = carry_flag_q;
      end
    endcase
  end

  always @* begin
    half_carry_flag_d = half_carry_flag_q;
    case (op_sel)
      OP_INVERT: begin
        half_carry_flag_d = half_carry_flag_q;
      end
      OP_ADJUST: begin
        half_carry_flag_d = half_carry_flag_q;
      end
      OP_NONE: begin
        if (flag_load) begin
          half_carry_flag_d = half_carry_wdata;
        end
      end
      default: begin
        half_carry_flag_d = half_carry_flag_q;
      end
    endcase
  end

  always @* begin
    mem_we_d = 1'h0;
    case (op_sel)
      OP_INVERT: begin
        mem_we_d = 1'h0;
      end
      OP_ADJUST: begin
        mem_we_d = 1'h1;
      end
      default: begin
        mem_we_d = 1'h0;
      end
    endcase
  end

  always @* begin
    mem_wdata_d = mem_wdata_q;
    case (op_sel)
      OP_ADJUST: begin
        mem_wdata_d = adj_result;
      end
      default: begin
        mem_wdata_d = mem_wdata_q;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // write data holds between adjusts so memory may latch it late
  always @(posedge core_clk) begin
    if (sys_rst) begin
      acc_q <= `ACC_RST;
      zero_flag_q <= `FLAG_RST;
      carry_flag_q <= `FLAG_RST;
      half_carry_flag_q <= `FLAG_RST;
      mem_we_q <= `FLAG_RST;
      mem_wdata_q <= `ACC_RST;
    end else begin
      acc_q <= acc_d;
      zero_flag_q <= zero_flag_d;
      carry_flag_q <= carry_flag_d;
      half_carry_flag_q <= half_carry_flag_d;
      mem_we_q <= mem_we_d;
      mem_wdata_q <= mem_wdata_d;
    end
  end
endmodule
`default_nettype wire

// ==== bench/alu_chk_sva.sv ====
/* checker of the alu slice; sees only the ports of its top */
`default_nettype none
module alu_chk(input wire logic core_clk,sys_rst,complement_to_accumulator,
decimal_adjust_to_memory,zero_flag_q,carry_flag_q,half_carry_flag_q,mem_we_q,
input wire logic [7:0] mem_rdata,acc_q,mem_wdata_q);
  wire c=complement_to_accumulator;
  wire d=decimal_adjust_to_memory&~c;
  // both tests on the byte as it stands
  wire [8:0] s=acc_q+{acc_q[7:4]>4'h9||carry_flag_q?4'h6:4'h0,
    acc_q[3:0]>4'h9||half_carry_flag_q?4'h6:4'h0};
  default clocking @(posedge core_clk);endclocking
  default disable iff(sys_rst);
  a_cpl_acc:assert property(c|=>acc_q==~$past(mem_rdata))else $error("acc");
  a_cpl_zero:assert property(c|=>zero_flag_q==(acc_q==8'h00))else $error("z");
  a_cpl_cy:assert property(c|=>$stable(carry_flag_q))else $error("c");
  a_no_wr:assert property(!d|=>!mem_we_q)else $error("we");
  a_adj_wr:assert property(d|=>mem_we_q&&$stable(acc_q))else $error("we");
  a_adj_val:assert property(d|=>mem_wdata_q==$past(s[7:0]))else $error("v");
  a_adj_flag:assert property(d|=>$stable({zero_flag_q,half_carry_flag_q}))else $error("f");
  a_adj_cy:assert property(d|=>carry_flag_q==$past(carry_flag_q|s[8]))else $error("c");
  cover property(c);
  cover property(d##1 d);
  cover property(d&&s[8]);
endmodule
bind complement_and_decimal_adjust_alu alu_chk u_chk(.*);
`default_nettype wire

// ==== bench/tb.sv ====
/* bench of the alu slice; needs the logic files */
`default_nettype none
module tb;
  timeunit 1ns;timeprecision 1ps;
  logic core_clk=0,sys_rst=1,complement_to_accumulator=0,decimal_adjust_to_memory=0;
  logic acc_load=0,flag_load=0,zero_wdata=0,carry_wdata=0,half_carry_wdata=0;
  logic zero_flag_q,carry_flag_q,half_carry_flag_q,mem_we_q;
  logic [7:0] mem_rdata=8'h00,acc_wdata=8'h00,acc_q,mem_wdata_q;
  int bad_count=0,n_compared=0;
`define CK(n,e,g) begin n_compared++;if((g)!==(e))begin bad_count++;\
$display("Error %s exp %h got %h",n,e,g);end end
  complement_and_decimal_adjust_alu u_complement_and_decimal_adjust_alu(
    .core_clk(core_clk),.sys_rst(sys_rst),
    .complement_to_accumulator(complement_to_accumulator),
    .decimal_adjust_to_memory(decimal_adjust_to_memory),.mem_rdata(mem_rdata),
    .acc_load(acc_load),.acc_wdata(acc_wdata),.flag_load(flag_load),
    .zero_wdata(zero_wdata),.carry_wdata(carry_wdata),.half_carry_wdata(half_carry_wdata),
    .acc_q(acc_q),.zero_flag_q(zero_flag_q),.carry_flag_q(carry_flag_q),
    .half_carry_flag_q(half_carry_flag_q),.mem_we_q(mem_we_q),.mem_wdata_q(mem_wdata_q));
  initial forever #5 core_clk=~core_clk;
  task st;@(posedge core_clk);#1;endtask
  task ld(input [7:0] a,input [2:0] f);
    {acc_load,flag_load,acc_wdata,zero_wdata,carry_wdata,half_carry_wdata}={2'h3,a,f};st;
  endtask
  // load stays high in the strobe cycle: must be ignored
  task t_cpl(input [7:0] m,input [7:0] e,input ez);
    ld(8'h55,{~ez,2'h2});{complement_to_accumulator,mem_rdata,acc_wdata}={1'b1,m,8'h11};st;
    {complement_to_accumulator,acc_load,flag_load}=0;
    `CK("acc",e,acc_q)
    `CK("z",ez,zero_flag_q)
    `CK("we",1'b0,mem_we_q)
    `CK("cy",1'b1,carry_flag_q)
    st;
  endtask
  // loads carry inverted values in the strobe cycle: must be ignored
  task t_adj(input [7:0] a,input [2:0] f,input [7:0] e,input ec);
    ld(a,f);
    {decimal_adjust_to_memory,acc_wdata,zero_wdata,carry_wdata,half_carry_wdata}={1'b1,~a,~f};
    st;
    {decimal_adjust_to_memory,acc_load,flag_load}=0;
    `CK("wd",e,mem_wdata_q)
    `CK("cy",ec,carry_flag_q)
    `CK("we",1'b1,mem_we_q)
    `CK("acc",a,acc_q)
    `CK("zh",{f[2],f[0]},{zero_flag_q,half_carry_flag_q})
    st;
    `CK("we1",1'b0,mem_we_q)
  endtask
  // two adjusts back to back with the strobe held
  task t_b2b;
    ld(8'hAA,3'h0);{decimal_adjust_to_memory,acc_load,flag_load}=3'h4;st;
    `CK("we",1'b1,mem_we_q)
    `CK("wd",8'h10,mem_wdata_q)
    st;decimal_adjust_to_memory=0;
    `CK("we",1'b1,mem_we_q)
    `CK("cy",1'b1,carry_flag_q)
    `CK("wd",8'h10,mem_wdata_q)
    st;
    `CK("we1",1'b0,mem_we_q)
  endtask
  task give_verdict;
    $display("compared %0d bad %0d",n_compared,bad_count);
    if(bad_count==0&&n_compared>0)$display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin repeat(400)@(posedge core_clk);bad_count++;give_verdict;end
  initial begin
    repeat(16)@(posedge core_clk);#1 sys_rst=0;
    t_cpl(8'hFF,8'h00,1'b1);
    t_cpl(8'h5A,8'hA5,1'b0);
    t_adj(8'h15,3'h1,8'h1B,1'b0);
    t_adj(8'h3C,3'h0,8'h42,1'b0);
    t_adj(8'h99,3'h0,8'h99,1'b0);
    t_adj(8'h38,3'h2,8'h98,1'b1);
    t_adj(8'hA3,3'h0,8'h03,1'b1);
    t_adj(8'h9A,3'h0,8'hA0,1'b0);
    t_adj(8'h42,3'h0,8'h42,1'b0);
    t_adj(8'hAA,3'h0,8'h10,1'b1);
    t_b2b;
    give_verdict;
  end
endmodule
`default_nettype wire
